// *** lcd_timing_pkg.sv ***
package lcd_timing_pkg;

    // Reference clock and the line clock it is divided into
    localparam int CLK_PERIOD_NS      = 25;
    localparam int LINE_PERIOD_NS     = 8000;
    localparam int LINE_DIV_CYCLES    = (LINE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LINE_DIV_WIDTH     = 16;

    // Lines per frame before the polarity flips
    localparam int DUTY_LINES         = 33;
    localparam int LINE_COUNT_WIDTH   = 8;

    // Row geometry
    localparam int ROW_BITS           = 132;
    localparam int SEG_COUNT          = 133;
    localparam int LINE_ADDR_WIDTH    = 6;
    localparam int CMD_DATA_WIDTH     = 6;

    // Word carried to the segment side: control bits above the row
    localparam int WORD_POL_BIT       = ROW_BITS + 3;
    localparam int WORD_ON_BIT        = ROW_BITS + 2;
    localparam int WORD_REV_BIT       = ROW_BITS + 1;
    localparam int WORD_ALL_BIT       = ROW_BITS;
    localparam int WORD_WIDTH         = ROW_BITS + 4;

    // Power control fields
    localparam int PWR_WIDTH          = 3;
    localparam int PWR_BOOSTER_BIT    = 2;
    localparam int PWR_REGULATOR_BIT  = 1;
    localparam int PWR_FOLLOWER_BIT   = 0;
    localparam logic [2:0] PWR_RESET  = 3'h0;

    // Reset values of display controls
    localparam logic [5:0] START_LINE_RESET = 6'h00;
    localparam logic DISPLAY_ON_RESET       = 1'b0;
    localparam logic REVERSE_RESET          = 1'b0;
    localparam logic ALL_ON_RESET           = 1'b0;

    // Command opcodes on the command port
    typedef enum logic [2:0] {
        CMD_START_LINE = 3'h0,
        CMD_POWER      = 3'h1,
        CMD_REVERSE    = 3'h2,
        CMD_DISPLAY_ON = 3'h3,
        CMD_ALL_ON     = 3'h4
    } cmd_op_t;

    // Row fetch sequencer
    typedef enum {
        FETCH_IDLE,
        FETCH_READ,
        FETCH_PUSH
    } fetch_state_t;

endpackage

// *** bit_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for levels entering a clock domain
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async,
    output logic      [WIDTH-1:0] synced
);

    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            synced <= '0;
        end else begin
            stage1 <= async;
            synced <= stage1;
        end
    end

endmodule

`default_nettype wire

// *** row_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none

// Two-entry FIFO; a stalled reader pushes back on the writer
module row_buffer #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);

    logic [WIDTH-1:0] mem [2];
    logic             wrPtr;
    logic             rdPtr;
    logic [1:0]       count;
    logic             doWrite;
    logic             doRead;

    assign inReady  = (count != 2'h2);
    assign outValid = (count != 2'h0);
    assign outData  = mem[rdPtr];
    assign doWrite  = inValid && inReady;
    assign doRead   = outValid && outReady;

    // Storage
    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr <= 1'b0;
            rdPtr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (doWrite) begin
                wrPtr <= ~wrPtr;
            end
            if (doRead) begin
                rdPtr <= ~rdPtr;
            end
            if (doWrite && !doRead) begin
                count <= count + 2'h1;
            end else if (doRead && !doWrite) begin
                count <= count - 2'h1;
            end
        end
    end

endmodule

`default_nettype wire

// *** lcd_line_timing_power_ctrl.sv ***
// Function
// - Line address steps with the line clock
// - Each line clock latches a 132-bit row
// - Row readout independent of host RAM access
// - Polarity alternates over a two-frame period
// - Slave takes polarity and line clock in
// - Master polarity change gives one scan-start pulse
// - Scan-start driven in master, else released
// - Master divides oscillator into line clock
// - Oscillator runs only in master mode
// - Latch output gated by display commands
// - 133 segments pick one of four levels
// - Power command loads booster, regulator, follower
// - Booster enabled implies oscillator running
// - Power circuit only usable as master
// - Polarity change presets line counter from start
`timescale 1ns/1ps
`default_nettype none

module lcd_line_timing_power_ctrl #(
    parameter int DIV_CYCLES = lcd_timing_pkg::LINE_DIV_CYCLES,
    parameter int DUTY       = lcd_timing_pkg::DUTY_LINES
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         segClk,
    input  wire logic         masterMode,
    // Command port
    input  wire logic         cmdValid,
    input  wire logic [2:0]   cmdOp,
    input  wire logic [5:0]   cmdData,
    // Row read port of the display RAM
    output logic              rowReadReq,
    output logic      [5:0]   rowReadAddr,
    input  wire logic [131:0] rowReadData,
    // Timing pins; scan start output only, the rest two-way
    input  wire logic         displayLineClockIn,
    output logic              displayLineClockOut,
    output logic              displayLineClockOe_n,
    input  wire logic         acFramePolarityIn,
    output logic              acFramePolarityOut,
    output logic              acFramePolarityOe_n,
    input  wire logic         displayOffSyncIn,
    output logic              displayOffSyncOut,
    output logic              displayOffSyncOe_n,
    output logic              commonScanStartOut,
    output logic              commonScanStartOe_n,
    // Power circuit enables
    output logic              oscEnable,
    output logic              boosterEnable,
    output logic              regulatorEnable,
    output logic              followerEnable,
    // Status and panel drive
    output logic      [5:0]   lineAddress,
    output logic              rowOverrun,
    output logic      [265:0] segmentLevel
);

    localparam int LW = lcd_timing_pkg::LINE_DIV_WIDTH;
    localparam int CW = lcd_timing_pkg::LINE_COUNT_WIDTH;
    localparam int WW = lcd_timing_pkg::WORD_WIDTH;
    localparam logic [LW-1:0] DIV_LAST  = LW'(DIV_CYCLES - 1);
    localparam logic [LW-1:0] DIV_HALF  = LW'(DIV_CYCLES / 2);
    localparam logic [CW-1:0] DUTY_LAST = CW'(DUTY - 1);

    // Level of one segment from pixel and polarity
    function automatic logic [1:0] segLevelOf(input logic pixel, input logic pol);
        segLevelOf = {pol, pixel};
    endfunction

    // Pin synchronisers
    logic [3:0] pinSync;
    logic       masterSync;
    logic       extLineClk;
    logic       extPolarity;
    logic       extDisplayOff;

    bit_sync #(.WIDTH(4)) pinSyncer (
        .clk    (ref_clk),
        .rst    (rst),
        .async  ({masterMode, displayLineClockIn, acFramePolarityIn, displayOffSyncIn}),
        .synced (pinSync)
    );

    assign masterSync    = pinSync[3];
    assign extLineClk    = pinSync[2];
    assign extPolarity   = pinSync[1];
    assign extDisplayOff = pinSync[0];

    // Command registers
    logic [5:0] startLine;
    logic [2:0] powerCtrl;
    logic       displayOn;
    logic       reverse;
    logic       allOn;

    // Display commands change only the gating, never the row data
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            startLine <= lcd_timing_pkg::START_LINE_RESET;
            powerCtrl <= lcd_timing_pkg::PWR_RESET;
            displayOn <= lcd_timing_pkg::DISPLAY_ON_RESET;
            reverse   <= lcd_timing_pkg::REVERSE_RESET;
            allOn     <= lcd_timing_pkg::ALL_ON_RESET;
        end else if (cmdValid) begin
            case (cmdOp)
                lcd_timing_pkg::CMD_START_LINE: startLine <= cmdData;
                lcd_timing_pkg::CMD_POWER:      powerCtrl <= cmdData[2:0];
                lcd_timing_pkg::CMD_REVERSE:    reverse   <= cmdData[0];
                lcd_timing_pkg::CMD_DISPLAY_ON: displayOn <= cmdData[0];
                lcd_timing_pkg::CMD_ALL_ON:     allOn     <= cmdData[0];
                default: begin
                end
            endcase
        end
    end

    // Power circuit
    // Oscillator follows master mode; booster can only be on with it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            oscEnable       <= 1'b0;
            boosterEnable   <= 1'b0;
            regulatorEnable <= 1'b0;
            followerEnable  <= 1'b0;
        end else begin
            oscEnable       <= masterSync;
            boosterEnable   <= masterSync && powerCtrl[lcd_timing_pkg::PWR_BOOSTER_BIT];
            regulatorEnable <= masterSync && powerCtrl[lcd_timing_pkg::PWR_REGULATOR_BIT];
            followerEnable  <= masterSync && powerCtrl[lcd_timing_pkg::PWR_FOLLOWER_BIT];
        end
    end

    // Line clock divider (master)
    logic [LW-1:0] divCount;
    logic          lineClk;

    // Divider halts while slave so a stale clock never drives the pin
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            divCount <= '0;
            lineClk  <= 1'b0;
        end else if (!masterSync) begin
            divCount <= '0;
            lineClk  <= 1'b0;
        end else begin
            divCount <= (divCount == DIV_LAST) ? '0 : divCount + LW'(1);
            lineClk  <= (divCount < DIV_HALF);
        end
    end

    // Trailing-edge detect
    logic curLineClk;
    logic prevLineClk;
    logic prevExtPol;
    logic lineTick;
    logic extPolFlip;

    assign curLineClk = masterSync ? lineClk : extLineClk;
    assign lineTick   = prevLineClk && !curLineClk;
    assign extPolFlip = (prevExtPol != extPolarity);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prevLineClk <= 1'b0;
            prevExtPol  <= 1'b0;
        end else begin
            prevLineClk <= curLineClk;
            prevExtPol  <= extPolarity;
        end
    end

    // Line counter and polarity
    logic [CW-1:0] lineCount;
    logic          polarity;
    logic          frameEnd;
    logic          presetNow;

    assign frameEnd  = (lineCount == DUTY_LAST);
    assign presetNow = masterSync ? (lineTick && frameEnd) : extPolFlip;

    // Master flips polarity every frame, giving a two-frame period
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            polarity <= 1'b0;
        end else if (!masterSync) begin
            polarity <= extPolarity;
        end else if (lineTick && frameEnd) begin
            polarity <= ~polarity;
        end
    end

    // Address presets on polarity change, otherwise steps per line
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lineCount   <= '0;
            lineAddress <= lcd_timing_pkg::START_LINE_RESET;
        end else if (presetNow) begin
            lineCount   <= '0;
            lineAddress <= startLine;
        end else if (lineTick) begin
            lineCount   <= frameEnd ? '0 : lineCount + CW'(1);
            lineAddress <= lineAddress + 6'h01;
        end
    end

    // Timing pin drivers
    // On the master, scan start high for the line that follows a polarity flip; held low on a slave
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            commonScanStartOut  <= 1'b0;
            commonScanStartOe_n <= 1'b1;
        end else begin
            commonScanStartOe_n <= ~masterSync;
            if (!masterSync) begin
                commonScanStartOut <= 1'b0;
            end else if (lineTick) begin
                commonScanStartOut <= frameEnd;
            end
        end
    end

    // Outputs on the master, released on a slave
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            displayLineClockOut  <= 1'b0;
            displayLineClockOe_n <= 1'b1;
            acFramePolarityOut   <= 1'b0;
            acFramePolarityOe_n  <= 1'b1;
            displayOffSyncOut    <= 1'b0;
            displayOffSyncOe_n   <= 1'b1;
        end else begin
            displayLineClockOut  <= lineClk;
            displayLineClockOe_n <= ~masterSync;
            acFramePolarityOut   <= polarity;
            acFramePolarityOe_n  <= ~masterSync;
            displayOffSyncOut    <= ~displayOn;
            displayOffSyncOe_n   <= ~masterSync;
        end
    end

    // Row fetch
    // Own read port, so host RAM traffic never stalls the refresh
    lcd_timing_pkg::fetch_state_t fetchState;
    logic [WW-1:0] fetchWord;
    logic          bufInReady;
    logic          bufOutValid;
    logic          bufOutReady;
    logic [WW-1:0] bufOutData;
    logic          effectiveOn;

    assign effectiveOn = masterSync ? displayOn : ~extDisplayOff;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fetchState  <= lcd_timing_pkg::FETCH_IDLE;
            rowReadReq  <= 1'b0;
            rowReadAddr <= 6'h00;
            fetchWord   <= '0;
            rowOverrun  <= 1'b0;
        end else begin
            rowReadReq <= 1'b0;
            case (fetchState)
                lcd_timing_pkg::FETCH_IDLE: begin
                    if (lineTick) begin
                        rowReadReq  <= 1'b1;
                        rowReadAddr <= lineAddress;
                        fetchState  <= lcd_timing_pkg::FETCH_READ;
                    end
                end
                lcd_timing_pkg::FETCH_READ: begin
                    fetchWord  <= {polarity, effectiveOn, reverse, allOn, rowReadData};
                    fetchState <= lcd_timing_pkg::FETCH_PUSH;
                end
                lcd_timing_pkg::FETCH_PUSH: begin
                    if (bufInReady) begin
                        fetchState <= lcd_timing_pkg::FETCH_IDLE;
                    end else if (lineTick) begin
                        rowOverrun <= 1'b1; // Sticky, line clock too fast for panel side
                    end
                end
                default: fetchState <= lcd_timing_pkg::FETCH_IDLE;
            endcase
        end
    end

    row_buffer #(.WIDTH(WW)) rowBuf (
        .clk      (ref_clk),
        .rst      (rst),
        .inValid  (fetchState == lcd_timing_pkg::FETCH_PUSH),
        .inReady  (bufInReady),
        .inData   (fetchWord),
        .outValid (bufOutValid),
        .outReady (bufOutReady),
        .outData  (bufOutData)
    );

    // Handshake into the segment domain
    logic [WW-1:0] xferWord;
    logic          reqToggle;
    logic          ackSynced;
    logic          xferBusy;

    assign xferBusy    = (reqToggle != ackSynced);
    assign bufOutReady = !xferBusy;

    // Word held stable while the request toggle is outstanding
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            xferWord  <= '0;
            reqToggle <= 1'b0;
        end else if (bufOutValid && !xferBusy) begin
            xferWord  <= bufOutData;
            reqToggle <= ~reqToggle;
        end
    end

    logic segReqSynced;
    logic ackToggle;

    bit_sync #(.WIDTH(1)) ackSyncer (
        .clk    (ref_clk),
        .rst    (rst),
        .async  (ackToggle),
        .synced (ackSynced)
    );

    bit_sync #(.WIDTH(1)) reqSyncer (
        .clk    (segClk),
        .rst    (rst),
        .async  (reqToggle),
        .synced (segReqSynced)
    );

    // Row latch and segment drive
    logic [WW-1:0] rowLatch;

    // Latch holds one row for a whole common period
    always_ff @(posedge segClk or posedge rst) begin
        if (rst) begin
            rowLatch  <= '0;
            ackToggle <= 1'b0;
        end else if (segReqSynced != ackToggle) begin
            rowLatch  <= xferWord;
            ackToggle <= segReqSynced;
        end
    end

    logic [265:0] next_segmentLevel;

    // Gating never touches the latched data, only what drives the pins
    always_comb begin
        logic pixel;
        pixel = 1'b0;
        for (int i = 0; i < lcd_timing_pkg::SEG_COUNT; i++) begin
            if (i < lcd_timing_pkg::ROW_BITS) begin
                pixel = rowLatch[lcd_timing_pkg::WORD_ALL_BIT]
                      | (rowLatch[i] ^ rowLatch[lcd_timing_pkg::WORD_REV_BIT]);
            end else begin
                pixel = rowLatch[lcd_timing_pkg::WORD_ALL_BIT]; // Spare segment shows only all-on
            end
            pixel = pixel & rowLatch[lcd_timing_pkg::WORD_ON_BIT];
            next_segmentLevel[2*i +: 2] = segLevelOf(pixel, rowLatch[lcd_timing_pkg::WORD_POL_BIT]);
        end
    end

    always_ff @(posedge segClk or posedge rst) begin
        if (rst) begin
            segmentLevel <= '0;
        end else begin
            segmentLevel <= next_segmentLevel;
        end
    end

endmodule

`default_nettype wire

// *** lcd_line_timing_power_ctrl_props.sv ***
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of line timing, pin direction and power enables
module lcd_line_timing_power_ctrl_props #(
    parameter int DIV_CYCLES = 8,
    parameter int DUTY       = 4
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       masterMode,
    input  wire logic       cmdValid,
    input  wire logic [2:0] cmdOp,
    input  wire logic [5:0] cmdData,
    input  wire logic       rowReadReq,
    input  wire logic       displayLineClockOut,
    input  wire logic       displayLineClockOe_n,
    input  wire logic       acFramePolarityOut,
    input  wire logic       acFramePolarityOe_n,
    input  wire logic       commonScanStartOut,
    input  wire logic       commonScanStartOe_n,
    input  wire logic       oscEnable,
    input  wire logic       boosterEnable,
    input  wire logic       regulatorEnable,
    input  wire logic       followerEnable,
    input  wire logic [5:0] lineAddress
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic        lineQ;
    logic        polQ;
    logic        fallNow;
    logic [3:0]  fallSh;
    logic [7:0]  linesSeen;
    logic [15:0] pulseLen;

    assign fallNow = lineQ & ~displayLineClockOut;

    // Line clock falls kept a few cycles, for latency slack
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lineQ <= 1'b0;
            fallSh <= 4'h0;
        end else begin
            lineQ <= displayLineClockOut;
            fallSh <= {fallSh[2:0], fallNow};
        end
    end

    // Lines seen since the last polarity flip
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            polQ <= 1'b0;
            linesSeen <= 8'h00;
        end else begin
            polQ <= acFramePolarityOut;
            if (polQ != acFramePolarityOut)
                linesSeen <= 8'(fallNow);
            else if (fallNow)
                linesSeen <= linesSeen + 8'h01;
        end
    end

    // Length of the scan-start pulse in cycles
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            pulseLen <= 16'h0000;
        else
            pulseLen <= commonScanStartOut ? pulseLen + 16'h0001 : 16'h0000;
    end

    sequence power_cmd;
        masterMode [*4] ##0 (cmdValid && cmdOp == lcd_timing_pkg::CMD_POWER);
    endsequence
    sequence slave_settled;
        !masterMode [*4];
    endsequence

    pins_released_a: assert property (slave_settled |-> displayLineClockOe_n && acFramePolarityOe_n)
        else $error("slave drives pins");
    scan_idle_slave_a: assert property (slave_settled |-> commonScanStartOe_n && !commonScanStartOut)
        else $error("slave drives scan start");
    osc_slave_a: assert property (slave_settled |-> !oscEnable)
        else $error("slave oscillator on");
    power_slave_a: assert property (slave_settled |-> !(boosterEnable || regulatorEnable || followerEnable))
        else $error("slave power on");
    master_drive_a: assert property (masterMode [*4] |-> oscEnable && !displayLineClockOe_n)
        else $error("master not driving");
    booster_osc_a: assert property (boosterEnable |-> oscEnable)
        else $error("booster on without oscillator");
    power_load_a: assert property (power_cmd |-> ##2
        ({boosterEnable, regulatorEnable, followerEnable} == $past(cmdData[2:0], 2)))
        else $error("power enables wrong");
    line_step_a: assert property (masterMode && $past(masterMode, 6) && $changed(lineAddress)
        |-> fallNow || (|fallSh))
        else $error("address moved off tick");
    row_fetch_a: assert property (masterMode && fallNow |-> ##[0:4] rowReadReq)
        else $error("no row fetch");
    frame_len_a: assert property (masterMode && polQ != acFramePolarityOut |-> linesSeen == DUTY)
        else $error("wrong frame length");
    scan_pulse_a: assert property (masterMode && $changed(acFramePolarityOut) |-> ##[0:2] commonScanStartOut)
        else $error("no scan start");
    scan_len_a: assert property (masterMode && $fell(commonScanStartOut) |-> pulseLen == DIV_CYCLES)
        else $error("scan pulse length");
endmodule

bind lcd_line_timing_power_ctrl lcd_line_timing_power_ctrl_props #(.DIV_CYCLES(DIV_CYCLES), .DUTY(DUTY)) chk (
    .ref_clk, .rst, .masterMode, .cmdValid, .cmdOp, .cmdData, .rowReadReq, .displayLineClockOut,
    .displayLineClockOe_n, .acFramePolarityOut, .acFramePolarityOe_n, .commonScanStartOut,
    .commonScanStartOe_n, .oscEnable, .boosterEnable, .regulatorEnable, .followerEnable, .lineAddress);

`default_nettype wire

// *** lcd_far_side_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Display RAM row port plus a master chip feeding a slave
module lcd_far_side_model #(
    parameter logic [131:0] ROW = 132'h0
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         rowReadReq,
    output logic      [131:0] rowReadData,
    input  wire logic         drive,
    input  wire logic         offReq,
    output logic              lineClk,
    output logic              framePol,
    output logic              dispOff
);
    logic       reqQ;
    logic [3:0] phase;
    logic [1:0] lines;

    // Row valid only around a read; otherwise inverted so stale data shows
    assign rowReadData = (rowReadReq || reqQ) ? ROW : ~ROW;
    assign lineClk     = drive & ~phase[3];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            reqQ <= 1'b0;
        else
            reqQ <= rowReadReq;
    end

    // Master side timing: 16-cycle line, four lines a frame
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase <= 4'h0;
            lines <= 2'h0;
            framePol <= 1'b0;
            dispOff <= 1'b0;
        end else begin
            dispOff <= offReq;
            if (drive) begin
                phase <= phase + 4'h1;
                if (phase == 4'hf) begin
                    lines <= lines + 2'h1;
                    if (lines == 2'h3)
                        framePol <= ~framePol;
                end
            end
        end
    end
endmodule

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam logic [131:0] ROW = {33{4'h5}};

    logic ref_clk = 1'b0, segClk = 1'b0, rst = 1'b1, masterMode = 1'b1;
    logic cmdValid = 1'b0, drive = 1'b0, offReq = 1'b0;
    logic [2:0] cmdOp = 3'h0;
    logic [5:0] cmdData = 6'h00;
    logic rowReadReq, lineOut, lineOe_n, polOut, polOe_n, offOut, offOe_n, scanOut, scanOe_n;
    logic osc, boost, regu, foll, overrun, mLine, mPol, mOff;
    logic [5:0] rowReadAddr, lineAddress;
    logic [131:0] rowReadData;
    logic [265:0] segmentLevel;
    int miscompares = 0, checked = 0;

    always #12.5 ref_clk = ~ref_clk;
    always #15 segClk = ~segClk;

    lcd_line_timing_power_ctrl #(.DIV_CYCLES(8), .DUTY(4)) DUT (
        .ref_clk, .rst, .segClk, .masterMode, .cmdValid, .cmdOp, .cmdData, .rowReadReq, .rowReadAddr,
        .rowReadData, .displayLineClockIn(lineOe_n ? mLine : lineOut),
        .displayLineClockOut(lineOut), .displayLineClockOe_n(lineOe_n),
        .acFramePolarityIn(polOe_n ? mPol : polOut), .acFramePolarityOut(polOut),
        .acFramePolarityOe_n(polOe_n), .displayOffSyncIn(offOe_n ? mOff : offOut),
        .displayOffSyncOut(offOut), .displayOffSyncOe_n(offOe_n), .commonScanStartOut(scanOut),
        .commonScanStartOe_n(scanOe_n), .oscEnable(osc), .boosterEnable(boost), .regulatorEnable(regu),
        .followerEnable(foll), .lineAddress, .rowOverrun(overrun), .segmentLevel);

    lcd_far_side_model #(.ROW(ROW)) far (
        .ref_clk, .rst, .rowReadReq, .rowReadData, .drive,
        .offReq, .lineClk(mLine), .framePol(mPol), .dispOff(mOff));

    task automatic check(input logic [265:0] seen, input logic [265:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One command, taken at the next edge
    task automatic cmd(input logic [2:0] op, input logic [5:0] data);
        @(posedge ref_clk);
        #1 cmdValid = 1'b1;
        cmdOp = op;
        cmdData = data;
        @(posedge ref_clk);
        #1 cmdValid = 1'b0;
    endtask

    // Poll pixel bits until match or timeout
    task automatic wait_pix(input logic [132:0] exp);
        logic [132:0] pix;
        int n;
        for (n = 0; n < 400; n++) begin
            @(posedge segClk);
            #1 for (int i = 0; i < 133; i++) pix[i] = segmentLevel[2*i];
            if (pix === exp) break;
        end
        check(pix, exp);
        if (n == 400) finish_test();
    endtask

    // Bounded wait on a named condition
    task automatic wait_cond(input int which, input logic level);
        int n;
        for (n = 0; n < 300; n++) begin
            @(posedge ref_clk);
            #2 if ((which == 0 ? scanOut : polOut) === level) break;
        end
        if (n == 300) begin
            check(1'b0, 1'b1);
            finish_test();
        end
    endtask

    initial begin
        logic [2:0] pwr [5] = '{3'h7, 3'h3, 3'h1, 3'h0, 3'h7};
        repeat (10) @(posedge ref_clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge ref_clk);
        foreach (pwr[k]) begin
            cmd(lcd_timing_pkg::CMD_POWER, {3'h0, pwr[k]});
            @(posedge ref_clk);
            #2 check({boost, regu, foll}, pwr[k]);
            check(osc, 1'b1);
        end
        $display("test power done");
        cmd(lcd_timing_pkg::CMD_DISPLAY_ON, 6'h01);
        wait_pix({1'b0, ROW});
        cmd(lcd_timing_pkg::CMD_REVERSE, 6'h01);
        wait_pix({1'b0, ~ROW});
        cmd(lcd_timing_pkg::CMD_ALL_ON, 6'h01);
        wait_pix({133{1'b1}});
        cmd(lcd_timing_pkg::CMD_ALL_ON, 6'h00);
        cmd(lcd_timing_pkg::CMD_REVERSE, 6'h00);
        cmd(lcd_timing_pkg::CMD_DISPLAY_ON, 6'h00);
        wait_pix(133'h0);
        check(offOut, 1'b1);
        $display("test display gating done");
        cmd(lcd_timing_pkg::CMD_START_LINE, 6'h2a);
        wait_cond(0, 1'b0);
        wait_cond(0, 1'b1);
        check(lineAddress, 6'h2a);
        check(scanOe_n, 1'b0);
        repeat (8) @(posedge ref_clk);
        #2 check(rowReadAddr, 6'h2a);
        $display("test start line done");
        @(posedge ref_clk) #1 masterMode = 1'b0;
        drive = 1'b1;
        cmd(lcd_timing_pkg::CMD_POWER, 6'h07);
        repeat (8) @(posedge ref_clk);
        #2 check({lineOe_n, polOe_n, offOe_n, scanOe_n, scanOut}, 5'h1e);
        check({osc, boost, regu, foll}, 4'h0);
        wait_pix({1'b0, ROW});
        @(posedge ref_clk);
        #1 offReq = 1'b1;
        wait_pix(133'h0);
        wait_cond(1, !polOut);
        check(lineAddress, 6'h2a);
        check(overrun, 1'b0);
        $display("test slave done");
        finish_test();
    end
endmodule

`default_nettype wire
